// ===== rtl/csw_alarm_timer.sv
// One watchdog alarm timer with sticky expiry flag
`include "csw_consts.svh"
module csw_alarm_timer
   import csw_pkg::*;
#(
   parameter int unsigned SHORT_CYC = 7250000,
   parameter int unsigned LONG_CYC = 29000000
)
(
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic enable, // Timer runs while high
   input wire logic clear, // Reload and drop the flag
   input wire logic tbase, // Time base select
   input wire logic [2:0] limit, // Units before expiry
   output logic expired // Sticky expiry flag
);
   // Refuse time bases the tick counter cannot serve
   if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
   begin
      $error("csw_alarm_timer: bad time base counts");
   end
   typedef struct packed
   {
      logic [31:0] tick;
      logic [2:0] units;
      logic flag;
   } csw_tmr_t;
   csw_tmr_t st_reg, st_next;
   logic [31:0] base_cyc;
   assign base_cyc = tbase ? 32'(LONG_CYC) : 32'(SHORT_CYC);
   // Count units while enabled; the flag holds until cleared
   always_comb
   begin
      st_next = st_reg;
      if (clear || !enable)
      begin
         st_next.tick = 32'h0;
         st_next.units = 3'h0;
      end
      else if (st_reg.tick >= base_cyc - 32'h1)
      begin
         st_next.tick = 32'h0;
         if (st_reg.units != 3'h7)
            st_next.units = st_reg.units + 3'h1;
      end
      else
         st_next.tick = st_reg.tick + 32'h1;
      // A clear in the same cycle wins: the reload takes priority
      if (clear)
         st_next.flag = 1'b0;
      if (enable && !clear && st_reg.units >= limit)
         st_next.flag = 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign expired = st_reg.flag;
endmodule

// ===== rtl/csw_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CSW_CONSTS_SVH
`define CSW_CONSTS_SVH
`define CSW_OFS_NSTEP 8'h05
`define CSW_OFS_BCNT 8'h06
`define CSW_OFS_DEVID 8'h07
`define CSW_OFS_VREV 8'h08
`define CSW_OFS_WDCTL 8'h09
`define CSW_OFS_WDSFT 8'h0a
`define CSW_BIT_SIO 7
`define CSW_BIT_CPU_PROG 6
`define CSW_BIT_SRC_PROG 5
`define CSW_BIT_TEST 4
`define CSW_BIT_HARD_EN 7
`define CSW_BIT_SOFT_EN 6
`define CSW_BIT_HARD_FLAG 5
`define CSW_BIT_SOFT_FLAG 4
`define CSW_BIT_TBASE 3
`define CSW_RST_VSEL 3'h5
`define CSW_RST_BCNT 6'h08
`define CSW_RST_HCNT 3'h7
`define CSW_RST_SCNT 3'h7
`define CSW_RST_SAFE 5'h04
`define CSW_SHORT_BASE_MS 290
`define CSW_LONG_BASE_MS 1160
`define CSW_CLK_KHZ 25000
`endif

// ===== rtl/csw_pkg.sv
// Types shared by the watchdog register bank
package csw_pkg;
   typedef struct packed
   {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csw_req_t;
   typedef struct packed
   {
      logic cpu_prog_en;
      logic src_prog_en;
      logic test_sel;
      logic [2:0] vsel;
      logic [5:0] bcnt;
      logic hard_en;
      logic soft_en;
      logic tbase;
      logic [2:0] hcnt;
      logic [2:0] scnt;
      logic [4:0] safe;
   } csw_cfg_t;
endpackage

// ===== rtl/csw_regs.sv
// Synthesizer control, identification and watchdog register bytes 5 to 10
`include "csw_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - serial rate bit read-only, latched at power-up
// - CPU and SRC divider programming enables
// - test mode sends reference divided to outputs
// - three-bit IO voltage select, resets to 101
// - six-bit byte count, default eight
// - device identifier byte read-only
// - revision high nibble, vendor low nibble, read-only
// - hard enable starts; clear reloads, clears flag
// - soft enable bit gates soft timer
// - alarm flags read-only, one when expired
// - time base bit selects short or long
// - hard count bits, default seven units
// - soft count bits, default seven units
// - safe frequency field used on hard expiry
module csw_regs
   import csw_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h3, // Arbitrary value
   parameter logic [3:0] VENDOR = 4'h9, // Arbitrary value
   parameter int unsigned SHORT_CYC =
      `CSW_SHORT_BASE_MS * (`CSW_CLK_KHZ),
   parameter int unsigned LONG_CYC =
      `CSW_LONG_BASE_MS * (`CSW_CLK_KHZ)
)
(
   input wire logic clk, // System clock, 25 MHz
   input wire logic rst_n, // Async reset, active low
   input wire csw_req_t req, // Register byte access from the serial port
   input wire logic sio_strap, // Serial rate strap pin
   output logic [7:0] rdata, // Read data, valid cycle after re
   output csw_cfg_t cfg, // Programmed configuration
   output logic hard_alarm, // Hard alarm flag
   output logic soft_alarm, // Soft alarm flag
   output logic safe_switch // High while outputs use safe setting
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      csw_cfg_t cfg;
      logic [2:0] strap_sync;
      logic [1:0] strap_fill;
      logic strap_done;
      logic sio_rate;
      logic [7:0] rdata;
      logic hard_clr;
      logic safe_sw;
   } csw_state_t;
   csw_state_t st_reg, st_next;
   logic hard_exp, soft_exp;
   // Refuse time bases the alarm timers cannot serve
   if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
   begin
      $error("csw_regs: bad time base counts");
   end
   ////////////////////////////////////////////////////////////////////////////
   // Timers
   csw_alarm_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_hard
   (
      .clk(clk),
      .rst_n(rst_n),
      .enable(st_reg.cfg.hard_en),
      .clear(st_reg.hard_clr),
      .tbase(st_reg.cfg.tbase),
      .limit(st_reg.cfg.hcnt),
      .expired(hard_exp)
   );
   csw_alarm_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_soft
   (
      .clk(clk),
      .rst_n(rst_n),
      .enable(st_reg.cfg.soft_en),
      .clear(1'b0),
      .tbase(st_reg.cfg.tbase),
      .limit(st_reg.cfg.scnt),
      .expired(soft_exp)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Register writes, reads and strap capture
   always_comb
   begin
      st_next = st_reg;
      st_next.hard_clr = 1'b0;
      st_next.strap_sync = {st_reg.strap_sync[1:0], sio_strap};
      // Stages hold reset zeros at first; wait until all carry pin samples
      if (st_reg.strap_fill != 2'h3)
         st_next.strap_fill = st_reg.strap_fill + 2'h1;
      // Strap taken once the second and third stages agree, then frozen
      if (!st_reg.strap_done && st_reg.strap_fill == 2'h3 &&
         st_reg.strap_sync[1] == st_reg.strap_sync[2])
      begin
         st_next.sio_rate = st_reg.strap_sync[2];
         st_next.strap_done = 1'b1;
      end
      if (req.we)
      begin
         case (req.addr)
            `CSW_OFS_NSTEP:
            begin
               st_next.cfg.cpu_prog_en = req.wdata[`CSW_BIT_CPU_PROG];
               st_next.cfg.src_prog_en = req.wdata[`CSW_BIT_SRC_PROG];
               st_next.cfg.test_sel = req.wdata[`CSW_BIT_TEST];
               st_next.cfg.vsel = req.wdata[2:0];
            end
            `CSW_OFS_BCNT:
               st_next.cfg.bcnt = req.wdata[5:0];
            `CSW_OFS_WDCTL:
            begin
               st_next.cfg.hard_en = req.wdata[`CSW_BIT_HARD_EN];
               st_next.hard_clr = !req.wdata[`CSW_BIT_HARD_EN];
               st_next.cfg.soft_en = req.wdata[`CSW_BIT_SOFT_EN];
               st_next.cfg.tbase = req.wdata[`CSW_BIT_TBASE];
               st_next.cfg.hcnt = req.wdata[2:0];
            end
            `CSW_OFS_WDSFT:
            begin
               st_next.cfg.scnt = req.wdata[7:5];
               st_next.cfg.safe = req.wdata[4:0];
            end
            default:
               st_next.cfg = st_reg.cfg; // Identifier bytes ignore writes
         endcase
      end
      if (req.re)
      begin
         case (req.addr)
            `CSW_OFS_NSTEP:
               st_next.rdata = {st_reg.sio_rate, st_reg.cfg.cpu_prog_en,
                  st_reg.cfg.src_prog_en, st_reg.cfg.test_sel, 1'b0,
                  st_reg.cfg.vsel};
            `CSW_OFS_BCNT:
               st_next.rdata = {2'b00, st_reg.cfg.bcnt};
            `CSW_OFS_DEVID:
               st_next.rdata = DEVICE_ID;
            `CSW_OFS_VREV:
               st_next.rdata = {REVISION, VENDOR};
            `CSW_OFS_WDCTL:
               st_next.rdata = {st_reg.cfg.hard_en, st_reg.cfg.soft_en,
                  hard_exp, soft_exp, st_reg.cfg.tbase,
                  st_reg.cfg.hcnt};
            `CSW_OFS_WDSFT:
               st_next.rdata = {st_reg.cfg.scnt, st_reg.cfg.safe};
            default:
               st_next.rdata = 8'h00;
         endcase
      end
      // Safe setting engaged by hard expiry, released by its clear
      st_next.safe_sw = hard_exp;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.cfg.vsel <= `CSW_RST_VSEL;
         st_reg.cfg.bcnt <= `CSW_RST_BCNT;
         st_reg.cfg.hcnt <= `CSW_RST_HCNT;
         st_reg.cfg.scnt <= `CSW_RST_SCNT;
         st_reg.cfg.safe <= `CSW_RST_SAFE;
      end
      else
         st_reg <= st_next;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign rdata = st_reg.rdata;
   assign cfg = st_reg.cfg;
   assign hard_alarm = hard_exp;
   assign soft_alarm = soft_exp;
   assign safe_switch = st_reg.safe_sw;
   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_idrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_DEVID |=> rdata == DEVICE_ID;
   endproperty
   a_idrd: assert property (p_idrd) else $error("id read wrong");
   property p_vrev;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_VREV |=> rdata == {REVISION, VENDOR};
   endproperty
   a_vrev: assert property (p_vrev) else $error("rev read wrong");
   property p_hclr;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDCTL && !req.wdata[`CSW_BIT_HARD_EN]
      |=> ##1 !hard_alarm;
   endproperty
   a_hclr: assert property (p_hclr) else $error("hard not cleared");
   property p_soff;
      @(posedge clk) disable iff (!rst_n)
      !cfg.soft_en && !soft_alarm |=> !soft_alarm;
   endproperty
   a_soff: assert property (p_soff) else $error("soft set idle");
   property p_bcnt;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_BCNT |=> cfg.bcnt == $past(req.wdata[5:0]);
   endproperty
   a_bcnt: assert property (p_bcnt) else $error("bcnt not stored");
   property p_wdrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_WDCTL
      |=> rdata[`CSW_BIT_HARD_FLAG] == $past(hard_alarm);
   endproperty
   a_wdrd: assert property (p_wdrd) else $error("flag read wrong");
   property p_sticky;
      @(posedge clk) disable iff (!rst_n)
      soft_alarm |=> soft_alarm;
   endproperty
   a_sticky: assert property (p_sticky) else $error("soft dropped");
   property p_safe;
      @(posedge clk) disable iff (!rst_n)
      $rose(hard_alarm) |=> safe_switch;
   endproperty
   a_safe: assert property (p_safe) else $error("no safe switch");
   property p_nst;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_NSTEP
      |=> cfg.test_sel == $past(req.wdata[`CSW_BIT_TEST]);
   endproperty
   a_nst: assert property (p_nst) else $error("test sel wrong");
   ////////////////////////////////////////////////////////////////////////////
   // Field stores: each write lands on cfg one cycle later
   property p_cpu;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_NSTEP
      |=> cfg.cpu_prog_en == $past(req.wdata[`CSW_BIT_CPU_PROG]);
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu en wrong");
   property p_src;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_NSTEP
      |=> cfg.src_prog_en == $past(req.wdata[`CSW_BIT_SRC_PROG]);
   endproperty
   a_src: assert property (p_src) else $error("src en wrong");
   property p_vsel;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_NSTEP
      |=> cfg.vsel == $past(req.wdata[2:0]);
   endproperty
   a_vsel: assert property (p_vsel) else $error("vsel wrong");
   property p_hen;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDCTL
      |=> cfg.hard_en == $past(req.wdata[`CSW_BIT_HARD_EN]);
   endproperty
   a_hen: assert property (p_hen) else $error("hard en wrong");
   property p_sen;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDCTL
      |=> cfg.soft_en == $past(req.wdata[`CSW_BIT_SOFT_EN]);
   endproperty
   a_sen: assert property (p_sen) else $error("soft en wrong");
   property p_tb;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDCTL
      |=> cfg.tbase == $past(req.wdata[`CSW_BIT_TBASE]);
   endproperty
   a_tb: assert property (p_tb) else $error("tbase wrong");
   property p_hcnt;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDCTL
      |=> cfg.hcnt == $past(req.wdata[2:0]);
   endproperty
   a_hcnt: assert property (p_hcnt) else $error("hcnt wrong");
   property p_scnt;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDSFT
      |=> cfg.scnt == $past(req.wdata[7:5]);
   endproperty
   a_scnt: assert property (p_scnt) else $error("scnt wrong");
   property p_sfq;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_WDSFT
      |=> cfg.safe == $past(req.wdata[4:0]);
   endproperty
   a_sfq: assert property (p_sfq) else $error("safe wrong");
   ////////////////////////////////////////////////////////////////////////////
   // Read-only bytes and bits: writes must leave every field alone
   property p_idwr;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_DEVID
      |=> $stable(cfg);
   endproperty
   a_idwr: assert property (p_idwr) else $error("id write took");
   property p_vrwr;
      @(posedge clk) disable iff (!rst_n)
      req.we && req.addr == `CSW_OFS_VREV
      |=> $stable(cfg);
   endproperty
   a_vrwr: assert property (p_vrwr) else $error("rev write took");
   property p_sioh;
      @(posedge clk) disable iff (!rst_n)
      st_reg.strap_done
      |=> $stable(st_reg.sio_rate);
   endproperty
   a_sioh: assert property (p_sioh) else $error("rate moved");
   ////////////////////////////////////////////////////////////////////////////
   // Readback: the byte shows the fields as they stood at the read
   property p_nsrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_NSTEP
      |=> !rdata[3] && rdata[2:0] == $past(cfg.vsel);
   endproperty
   a_nsrd: assert property (p_nsrd) else $error("byte5 read");
   property p_bcrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_BCNT
      |=> rdata == {2'b00, $past(cfg.bcnt)};
   endproperty
   a_bcrd: assert property (p_bcrd) else $error("bcnt read");
   property p_swrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_WDCTL
      |=> rdata[`CSW_BIT_SOFT_FLAG] == $past(soft_alarm);
   endproperty
   a_swrd: assert property (p_swrd) else $error("soft read");
   property p_wdlo;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_WDCTL
      |=> rdata[3:0] == $past({cfg.tbase, cfg.hcnt});
   endproperty
   a_wdlo: assert property (p_wdlo) else $error("byte9 read");
   property p_sfrd;
      @(posedge clk) disable iff (!rst_n)
      req.re && req.addr == `CSW_OFS_WDSFT
      |=> rdata == $past({cfg.scnt, cfg.safe});
   endproperty
   a_sfrd: assert property (p_sfrd) else $error("byte10 read");
   ////////////////////////////////////////////////////////////////////////////
   // Alarm behaviour: idle timers stay quiet, a set hard flag stays set until its clear
   property p_hoff;
      @(posedge clk) disable iff (!rst_n)
      !cfg.hard_en && !hard_alarm
      |=> !hard_alarm;
   endproperty
   a_hoff: assert property (p_hoff) else $error("hard set idle");
   property p_soff2;
      @(posedge clk) disable iff (!rst_n)
      !hard_alarm
      |=> !safe_switch;
   endproperty
   a_soff2: assert property (p_soff2) else $error("safe early");
   property p_hstk;
      @(posedge clk) disable iff (!rst_n)
      hard_alarm && !st_reg.hard_clr
      |=> hard_alarm;
   endproperty
   a_hstk: assert property (p_hstk) else $error("hard dropped");
endmodule

// ===== verification/csw_host.sv
// Register host model issuing byte requests into the bank
module csw_host
   import csw_pkg::*;
(
   input wire logic clk, // System clock
   output csw_req_t req // Byte request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   ////////////////////////////////////////////////////////////////////////////
   // One strobe for one edge; released lines carry inverted leftovers so
   // that stale values cannot pass for a held request
   task automatic xfer(input logic w, input logic [7:0] a, d);
      req <= '{we: w, re: !w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
      @(posedge clk);
   endtask
endmodule

// ===== verification/csw_regs_test.sv
// Self-checking bench for the watchdog register bank
module csw_regs_test
   import csw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sio_strap = 1'b1;
   csw_req_t req;
   logic [7:0] rdata;
   csw_cfg_t cfg;
   logic hard_alarm, soft_alarm, safe_switch;
   logic [2:0] fl;
   logic [31:0] seed = 32'hb4d87dc8;
   logic [7:0] a, d, v;
   int n_fail = 0;
   int checked = 0;
   assign fl = {safe_switch, soft_alarm, hard_alarm};
   always #20 clk = ~clk;
   csw_host u_host (.clk(clk), .req(req));
   // Short time bases keep alarm runs to a few dozen cycles
   csw_regs #(.SHORT_CYC(4), .LONG_CYC(16)) u_csw_regs (.clk(clk),
      .rst_n(rst_n), .req(req), .sio_strap(sio_strap), .rdata(rdata),
      .cfg(cfg), .hard_alarm(hard_alarm), .soft_alarm(soft_alarm),
      .safe_switch(safe_switch));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected readback after writing d; strap was high at power-up
   function automatic logic [7:0] exp_rd(input logic [7:0] a, d);
      case (a)
         8'h05: return (d & 8'h77) | 8'h80;
         8'h06: return d & 8'h3f;
         8'h07: return 8'h5a;
         8'h08: return 8'h39;
         8'h09: return d & 8'hcf;
         8'h0a: return d;
         default: return 8'h00;
      endcase
   endfunction
   // Power-up readback with the strap high
   function automatic logic [7:0] exp_rst(input logic [7:0] a);
      case (a)
         8'h05: return 8'h85;
         8'h06: return 8'h08;
         8'h07: return 8'h5a;
         8'h08: return 8'h39;
         8'h09: return 8'h07;
         8'h0a: return 8'he4;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask
   task automatic conclude;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [7:0] q);
      seed = lfsr(seed);
      u_host.xfer(1'b0, ad, seed[7:0]);
      q = rdata;
   endtask
   // Flag level looked at mid-cycle, away from the launching edge
   task automatic flag_is(input int sel, input logic e);
      @(negedge clk);
      chk({7'h0, fl[sel]}, {7'h0, e});
      @(posedge clk);
   endtask
   // Bounded wait for a flag; running out ends the run
   task automatic wait_hi(input int sel);
      for (int i = 0; i < 60; i++)
      begin
         @(negedge clk);
         if (fl[sel] === 1'b1)
         begin
            @(posedge clk);
            return;
         end
      end
      n_fail++;
      conclude();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      sio_strap <= 1'b0; // Must be ignored once latched
      // Reset value of every byte, plus two unmapped offsets past them
      for (int i = 0; i < 8; i++)
      begin
         a = 8'h05 + 8'(i);
         rd(a, v);
         chk(v, exp_rst(a));
      end
      rd(8'h09, v);
      chk(v, 8'h07);
      rd(8'h0a, v);
      chk(v, 8'he4);
      rd(8'h06, v);
      chk(v, 8'h08);
      chk({2'b0, cfg.bcnt}, 8'h08);
      chk({5'b0, cfg.vsel}, 8'h05);
      $display("reset values done");
      // Random writes, read-only bytes and an unmapped offset included
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         a = 8'h05 + 8'(seed[10:8] % 7);
         d = seed[7:0] & (a == 8'h09 ? 8'h3f : 8'hff);
         u_host.xfer(1'b1, a, d);
         rd(a, v);
         chk(v, exp_rd(a, d));
      end
      $display("random access done");
      // Hard alarm: two short units, then cleared by the enable bit
      u_host.xfer(1'b1, 8'h0a, 8'h24);
      u_host.xfer(1'b1, 8'h09, 8'h82);
      repeat (2) @(posedge clk);
      flag_is(0, 1'b0);
      wait_hi(0);
      flag_is(2, 1'b1);
      chk({3'b0, cfg.safe}, 8'h04);
      rd(8'h09, v);
      chk(v, 8'ha2);
      u_host.xfer(1'b1, 8'h09, 8'h02);
      flag_is(0, 1'b0);
      rd(8'h09, v);
      chk(v, 8'h02);
      // Long base: one unit must outlast eight cycles
      u_host.xfer(1'b1, 8'h09, 8'h89);
      repeat (8) @(posedge clk);
      flag_is(0, 1'b0);
      wait_hi(0);
      u_host.xfer(1'b1, 8'h09, 8'h08);
      flag_is(0, 1'b0);
      $display("hard alarm done");
      // Soft alarm: one short unit, flag stays after disable
      u_host.xfer(1'b1, 8'h09, 8'h40);
      wait_hi(1);
      u_host.xfer(1'b1, 8'h09, 8'h00);
      rd(8'h09, v);
      chk(v, 8'h10);
      flag_is(0, 1'b0);
      $display("soft alarm done");
      // Mid-run reset with the strap low: slow rate, flags and fields back
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({5'b0, fl}, 8'h00);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      rd(8'h05, v);
      chk(v, 8'h05);
      rd(8'h09, v);
      chk(v, 8'h07);
      $display("mid-run reset done");
      conclude();
   end
endmodule
